// *** design/ufrt_bit_tick.sv ***
// Full-speed bit-time strobe from the system clock
`timescale 1ns/1ns
`default_nettype none

module ufrt_bit_tick #(
    parameter int CLK_HZ = ufrt_pkg::CLK_HZ,
    parameter int BIT_HZ = ufrt_pkg::FS_BIT_HZ
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic run_in,
    output var  logic tick_out
);

    logic [31:0] phase;
    logic [31:0] next_phase;
    logic [31:0] sum;

    // Phase accumulator: exact average rate, jitter of one clock
    always_comb begin
        sum = phase + 32'(BIT_HZ);
        next_phase = (sum >= 32'(CLK_HZ)) ? sum - 32'(CLK_HZ) : sum;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase <= 32'h0;
        end else if (!run_in) begin
            phase <= 32'h0;
        end else begin
            phase <= next_phase;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= run_in && (sum >= 32'(CLK_HZ));
        end
    end

endmodule : ufrt_bit_tick

`default_nettype wire

// *** design/ufrt_frame_timing.sv ***
// Frame remaining and frame number counters with register port
`timescale 1ns/1ns
`default_nettype none

// Operation
// R1 - While running, the remaining-bits counter drops by one each full-speed bit time.
// R2 - Once the counter sits at zero it reloads the frame interval at the next bit time.
// R3 - Whenever the counter reaches zero the interval toggle is copied into bit 31.
// R4 - Entering the running state loads the counter from the interval field at once.
// R5 - The remaining toggle is read-only to software and resets to zero.
// R6 - Bits 30 to 14 of the remaining register read as zero and do nothing.
// R7 - The frame number steps by one at every reload, that is at each frame boundary.
// R8 - The frame number wraps from ffff to 0 and resets to zero.
// R9 - Entering the running state steps the frame number by one.
// R10 - After the step and the start-of-frame token, the number is written to shared memory
// R11 - When that memory write completes, the start-of-frame status flag is set.
// R12 - Frame number bits 31 to 16 read zero and software cannot write the number.
// R13 - Software inverts the interval toggle whenever it writes a new interval.
// R14 - The interval field resets to 2edf and returns there on a controller reset.
// R15 - Outside the running state the remaining counter holds its value.
module ufrt_frame_timing (
    input  wire logic                       clk_in,
    input  wire logic                       arst_n_in,
    input  wire ufrt_pkg::ufrt_reg_req_type reg_req_in,
    output var  logic [31:0]                reg_rdata_out,
    output logic                            sof_req_out,
    input  wire logic                       sof_ack_in,
    output var  ufrt_pkg::ufrt_mem_wr_type  mem_wr_out,
    input  wire logic                       mem_ack_in,
    output logic                            ed_fetch_go_out,
    output var  logic                       running_out,
    output logic                            irq_out
);

    localparam int IW = ufrt_pkg::INTERVAL_W;
    localparam int FW = ufrt_pkg::FRAME_COUNT_W;

    // Reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Register state
    logic [IW-1:0]                 interval_length_field;
    logic [ufrt_pkg::MAXPKT_W-1:0] max_packet;
    logic                          interval_toggle_bit;
    logic                          run;
    logic                          run_q;
    logic [31:0]                   comm_base;
    logic [ufrt_pkg::IRQ_W-1:0]    irq_status;
    logic [ufrt_pkg::IRQ_W-1:0]    irq_mask;

    // Counters
    logic [IW-1:0] bits_left_counter;
    logic          remaining_toggle_bit;
    logic [FW-1:0] frame_count_value;

    // Frame sequence
    ufrt_pkg::ufrt_seq_type seq;
    logic                   bit_tick;

    // Decoded accesses
    logic wr_interval;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic wr_base;
    logic hc_reset;
    logic run_entry;
    logic frame_boundary;
    logic sof_event;
    logic wrap_event;
    logic [ufrt_pkg::IRQ_W-1:0] irq_set;

    assign wr_interval = reg_req_in.wr && (reg_req_in.addr == ufrt_pkg::FM_INTERVAL_OFS);
    assign wr_ctrl     = reg_req_in.wr && (reg_req_in.addr == ufrt_pkg::CTRL_OFS);
    assign wr_status   = reg_req_in.wr && (reg_req_in.addr == ufrt_pkg::IRQ_STATUS_OFS);
    assign wr_mask     = reg_req_in.wr && (reg_req_in.addr == ufrt_pkg::IRQ_MASK_OFS);
    assign wr_base     = reg_req_in.wr && (reg_req_in.addr == ufrt_pkg::COMM_BASE_OFS);
    assign hc_reset    = wr_ctrl && reg_req_in.wdata[ufrt_pkg::HC_RESET_BIT];

    assign run_entry      = run && !run_q;
    assign frame_boundary = run_entry ||
                            (run_q && bit_tick && (bits_left_counter == '0));
    assign wrap_event     = frame_boundary && (frame_count_value == '1);

    ufrt_bit_tick #(
        .CLK_HZ (ufrt_pkg::CLK_HZ),
        .BIT_HZ (ufrt_pkg::FS_BIT_HZ)
    ) u_bit_tick (
        .clk_in   (clk_in),
        .rst_n_in (rst_n),
        .run_in   (run_q),
        .tick_out (bit_tick)
    );

    // Interval register; controller reset restores the nominal value
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            interval_length_field <= ufrt_pkg::INTERVAL_RST; // R14
            max_packet            <= ufrt_pkg::MAXPKT_RST;
            interval_toggle_bit   <= 1'b0;
        end else if (hc_reset) begin
            interval_length_field <= ufrt_pkg::INTERVAL_RST; // R14
            max_packet            <= ufrt_pkg::MAXPKT_RST;
            interval_toggle_bit   <= 1'b0;
        end else if (wr_interval) begin
            interval_length_field <= reg_req_in.wdata[IW-1:0];
            max_packet            <= reg_req_in.wdata[ufrt_pkg::MAXPKT_LSB +:
                                                      ufrt_pkg::MAXPKT_W];
            interval_toggle_bit   <= reg_req_in.wdata[ufrt_pkg::TOGGLE_BIT]; // R13
        end
    end

    // Control: run level, controller reset drops it
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            run   <= 1'b0;
            run_q <= 1'b0;
        end else begin
            run_q <= run;
            if (hc_reset) begin
                run <= 1'b0;
            end else if (wr_ctrl) begin
                run <= reg_req_in.wdata[ufrt_pkg::RUN_BIT];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            comm_base <= ufrt_pkg::COMM_BASE_RST;
        end else if (wr_base) begin
            comm_base <= {reg_req_in.wdata[31:2], 2'b00};
        end
    end

    // Remaining-bits down counter
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bits_left_counter <= ufrt_pkg::BITS_LEFT_RST;
        end else if (run_entry) begin
            bits_left_counter <= interval_length_field; // R4
        end else if (run_q && bit_tick) begin // R15
            if (bits_left_counter == '0) begin
                bits_left_counter <= interval_length_field; // R2
            end else begin
                bits_left_counter <= bits_left_counter - 1'b1; // R1
            end
        end
    end

    // Toggle follows the interval toggle as the count reaches zero
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            remaining_toggle_bit <= 1'b0; // R5
        end else if (hc_reset) begin
            remaining_toggle_bit <= 1'b0; // R5
        end else if (run_q && bit_tick && (bits_left_counter == {{(IW-1){1'b0}}, 1'b1})) begin
            remaining_toggle_bit <= interval_toggle_bit; // R3
        end
    end

    // Frame number, wraps naturally at all ones
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            frame_count_value <= ufrt_pkg::FRAME_COUNT_RST; // R8
        end else if (frame_boundary) begin
            frame_count_value <= frame_count_value + 1'b1; // R7 R8 R9
        end
    end

    // Boundary sequence: token, then memory write, then flag
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            seq <= ufrt_pkg::SEQ_IDLE;
        end else begin
            unique case (seq)
                ufrt_pkg::SEQ_IDLE: begin
                    if (frame_boundary) begin
                        seq <= ufrt_pkg::SEQ_SOF;
                    end
                end
                ufrt_pkg::SEQ_SOF: begin
                    if (sof_ack_in) begin
                        seq <= ufrt_pkg::SEQ_MEM; // R10
                    end
                end
                ufrt_pkg::SEQ_MEM: begin
                    if (mem_ack_in) begin
                        seq <= ufrt_pkg::SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // Write data captured once the number has stepped
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_out <= '0;
        end else begin
            if ((seq == ufrt_pkg::SEQ_SOF) && sof_ack_in) begin
                mem_wr_out.req  <= 1'b1; // R10
                mem_wr_out.addr <= comm_base + ufrt_pkg::COMM_FN_SLOT;
                mem_wr_out.data <= {{(32-FW){1'b0}}, frame_count_value};
            end else if ((seq == ufrt_pkg::SEQ_MEM) && mem_ack_in) begin
                mem_wr_out.req  <= 1'b0;
            end
        end
    end

    assign sof_req_out     = (seq == ufrt_pkg::SEQ_SOF);
    assign sof_event       = (seq == ufrt_pkg::SEQ_MEM) && mem_ack_in;
    assign ed_fetch_go_out = sof_event; // R10

    // Sticky status, write one to clear, set wins
    always_comb begin
        irq_set = '0;
        irq_set[ufrt_pkg::SOF_IRQ_BIT]  = sof_event; // R11
        irq_set[ufrt_pkg::WRAP_IRQ_BIT] = wrap_event;
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
        end else if (wr_status) begin
            irq_status <= (irq_status & ~reg_req_in.wdata[ufrt_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set; // R11
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= reg_req_in.wdata[ufrt_pkg::IRQ_W-1:0];
        end
    end

    assign irq_out = |(irq_status & irq_mask);

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            running_out <= 1'b0;
        end else begin
            running_out <= run_q;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 32'h0;
        end else if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                ufrt_pkg::FM_INTERVAL_OFS: begin
                    reg_rdata_out <= {interval_toggle_bit, max_packet, 2'b00,
                                      interval_length_field};
                end
                ufrt_pkg::BITS_LEFT_OFS: begin
                    reg_rdata_out <= {remaining_toggle_bit, 17'h0, bits_left_counter}; // R6
                end
                ufrt_pkg::FRAME_COUNT_OFS: begin
                    reg_rdata_out <= {16'h0, frame_count_value}; // R12
                end
                ufrt_pkg::CTRL_OFS: begin
                    reg_rdata_out <= {31'h0, run};
                end
                ufrt_pkg::IRQ_STATUS_OFS: begin
                    reg_rdata_out <= {30'h0, irq_status};
                end
                ufrt_pkg::IRQ_MASK_OFS: begin
                    reg_rdata_out <= {30'h0, irq_mask};
                end
                ufrt_pkg::COMM_BASE_OFS: begin
                    reg_rdata_out <= comm_base;
                end
                default: begin
                    reg_rdata_out <= 32'h0;
                end
            endcase
        end else begin
            reg_rdata_out <= 32'h0;
        end
    end

endmodule : ufrt_frame_timing

`default_nettype wire

// *** design/ufrt_pkg.sv ***
// Constants and carrier types of the frame timing block
package ufrt_pkg;

    // Register offsets
    localparam logic [15:0] FM_INTERVAL_OFS = 16'hd034;
    localparam logic [15:0] BITS_LEFT_OFS   = 16'hd038;
    localparam logic [15:0] FRAME_COUNT_OFS = 16'hd03c;
    localparam logic [15:0] CTRL_OFS        = 16'hd0f0;
    localparam logic [15:0] IRQ_STATUS_OFS  = 16'hd0f4;
    localparam logic [15:0] IRQ_MASK_OFS    = 16'hd0f8;
    localparam logic [15:0] COMM_BASE_OFS   = 16'hd0fc;

    // Field layout
    localparam int INTERVAL_W    = 14;
    localparam int MAXPKT_LSB    = 16;
    localparam int MAXPKT_W      = 15;
    localparam int TOGGLE_BIT    = 31;
    localparam int FRAME_COUNT_W = 16;
    localparam int RUN_BIT       = 0;
    localparam int HC_RESET_BIT  = 1;
    localparam int SOF_IRQ_BIT   = 0;
    localparam int WRAP_IRQ_BIT  = 1;
    localparam int IRQ_W         = 2;

    // Reset values
    localparam logic [INTERVAL_W-1:0]    INTERVAL_RST    = 14'h2edf;
    localparam logic [MAXPKT_W-1:0]      MAXPKT_RST      = 15'h0000;
    localparam logic [INTERVAL_W-1:0]    BITS_LEFT_RST   = 14'h0000;
    localparam logic [FRAME_COUNT_W-1:0] FRAME_COUNT_RST = 16'h0000;
    localparam logic [31:0]              COMM_BASE_RST   = 32'h0000_0000;

    // Frame number slot inside the shared communication area
    localparam logic [31:0] COMM_FN_SLOT = 32'h0000_0080;

    // Timing: system clock rate and full-speed bit rate, in hertz
    localparam int CLK_HZ    = 100_000_000;
    localparam int FS_BIT_HZ = 12_000_000;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ufrt_reg_req_type;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        logic [31:0] data;
    } ufrt_mem_wr_type;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SOF,
        SEQ_MEM
    } ufrt_seq_type;

endpackage : ufrt_pkg

// *** dv/tb_ufrt_frame_timing.sv ***
// Self-checking bench for the frame timing block
`timescale 1ns/1ns
`default_nettype none

module tb_ufrt_frame_timing;
    logic                       clk_in    = 1'b0;
    logic                       arst_n_in = 1'b0;
    ufrt_pkg::ufrt_reg_req_type req       = '0;
    logic [31:0]                rdata;
    logic                       sof_req;
    logic                       sof_ack   = 1'b0;
    ufrt_pkg::ufrt_mem_wr_type  mem_wr;
    logic                       mem_ack   = 1'b0;
    logic                       fetch_go;
    logic                       running;
    logic                       irq;
    logic [31:0]                v;
    logic [31:0]                last_data = '0;
    logic [31:0]                last_addr = '0;
    logic [31:0]                v0;
    int                         nfetch    = 0;
    int                         miscompares = 0;
    int                         comparisons = 0;

    always #5 clk_in = ~clk_in;

    ufrt_frame_timing ufrt_frame_timing_inst (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .sof_req_out(sof_req), .sof_ack_in(sof_ack), .mem_wr_out(mem_wr),
        .mem_ack_in(mem_ack), .ed_fetch_go_out(fetch_go), .running_out(running),
        .irq_out(irq));

    // Far side acknowledges one cycle after each request
    always @(posedge clk_in) begin
        sof_ack <= sof_req && !sof_ack;
        mem_ack <= mem_wr.req && !mem_ack;
        if (mem_wr.req && mem_ack) begin
            last_data <= mem_wr.data;
            last_addr <= mem_wr.addr;
        end
        if (fetch_go)
            nfetch <= nfetch + 1;
    end

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask : wr

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_in);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1 v = rdata;
        chk_val(v & m, e);
    endtask : rd_chk

    task automatic wait_fetch(input int n);
        for (int i = 0; i < 3000 && nfetch < n; i++)
            @(posedge clk_in);
        chk_bit(nfetch >= n, 1'b1);
    endtask : wait_fetch

    task automatic test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    initial begin
        #100000;
        miscompares++;
        test_done();
    end

    initial begin
        repeat (16) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd_chk(ufrt_pkg::FM_INTERVAL_OFS, 32'hffff_ffff, 32'h0000_2edf);
        rd_chk(ufrt_pkg::BITS_LEFT_OFS, 32'hffff_ffff, 32'h0);
        rd_chk(ufrt_pkg::FRAME_COUNT_OFS, 32'hffff_ffff, 32'h0);
        wr(ufrt_pkg::BITS_LEFT_OFS, 32'hffff_ffff);
        wr(ufrt_pkg::FRAME_COUNT_OFS, 32'hffff_ffff);
        rd_chk(ufrt_pkg::BITS_LEFT_OFS, 32'hffff_ffff, 32'h0);
        rd_chk(ufrt_pkg::FRAME_COUNT_OFS, 32'hffff_ffff, 32'h0);
        rd_chk(16'hd000, 32'hffff_ffff, 32'h0);
        // Short frame, toggle inverted with the new interval
        wr(ufrt_pkg::COMM_BASE_OFS, 32'h0001_2340);
        wr(ufrt_pkg::FM_INTERVAL_OFS, 32'h8000_0010);
        wr(ufrt_pkg::CTRL_OFS, 32'h0000_0001);
        wait_fetch(1);
        chk_val(last_data, 32'h0000_0001);
        chk_val(last_addr, 32'h0001_2340 + ufrt_pkg::COMM_FN_SLOT);
        chk_bit(running, 1'b1);
        chk_bit(irq, 1'b0);
        wait_fetch(3);
        rd_chk(ufrt_pkg::FRAME_COUNT_OFS, 32'hffff_ffff, 32'h3);
        rd_chk(ufrt_pkg::BITS_LEFT_OFS, 32'h8000_0000, 32'h8000_0000);
        chk_bit(v[13:0] <= 14'h0010, 1'b1);
        rd_chk(ufrt_pkg::BITS_LEFT_OFS, 32'h7fff_c000, 32'h0);
        // About five bit times pass in 42 clocks, well inside the frame
        v0 = v;
        repeat (40) @(posedge clk_in);
        rd_chk(ufrt_pkg::BITS_LEFT_OFS, 32'h8000_0000, 32'h8000_0000);
        chk_bit((v0[13:0] - v[13:0] >= 14'h4) && (v0[13:0] - v[13:0] <= 14'h6), 1'b1);
        wr(ufrt_pkg::CTRL_OFS, 32'h0);
        repeat (40) @(posedge clk_in);
        chk_bit(running, 1'b0);
        rd_chk(ufrt_pkg::BITS_LEFT_OFS, 32'h8000_0000, 32'h8000_0000);
        v0 = v;
        rd_chk(ufrt_pkg::IRQ_STATUS_OFS, 32'h1, 32'h1);
        wr(ufrt_pkg::IRQ_MASK_OFS, 32'h1);
        #1 chk_bit(irq, 1'b1);
        wr(ufrt_pkg::IRQ_STATUS_OFS, 32'h1);
        #1 chk_bit(irq, 1'b0);
        repeat (200) @(posedge clk_in);
        rd_chk(ufrt_pkg::FRAME_COUNT_OFS, 32'hffff_ffff, 32'h3);
        rd_chk(ufrt_pkg::BITS_LEFT_OFS, 32'h8000_0000, 32'h8000_0000);
        chk_val(v, v0);
        wr(ufrt_pkg::CTRL_OFS, 32'h2);
        rd_chk(ufrt_pkg::FM_INTERVAL_OFS, 32'hffff_ffff, 32'h0000_2edf);
        rd_chk(ufrt_pkg::BITS_LEFT_OFS, 32'h8000_0000, 32'h0);
        test_done();
    end
endmodule : tb_ufrt_frame_timing

`default_nettype wire

// *** dv/ufrt_frame_timing_checker.sv ***
// Concurrent checks on the frame timing block ports
`timescale 1ns/1ns
`default_nettype none

module ufrt_frame_timing_checker (
    input wire logic                       clk_in,
    input wire logic                       arst_n_in,
    input wire ufrt_pkg::ufrt_reg_req_type reg_req_in,
    input wire logic [31:0]                reg_rdata_out,
    input wire logic                       sof_req_out,
    input wire logic                       sof_ack_in,
    input wire ufrt_pkg::ufrt_mem_wr_type  mem_wr_out,
    input wire logic                       mem_ack_in,
    input wire logic                       ed_fetch_go_out,
    input wire logic                       running_out,
    input wire logic                       irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_rd(logic [15:0] a);
        reg_req_in.rd && reg_req_in.addr == a;
    endsequence
    sequence s_run_entry;
        reg_req_in.wr && reg_req_in.addr == ufrt_pkg::CTRL_OFS && reg_req_in.wdata[1:0] == 2'h1
            && !running_out && !sof_req_out && !mem_wr_out.req;
    endsequence
    sequence s_sof_sent;
        sof_req_out && sof_ack_in;
    endsequence
    sequence s_write_done;
        mem_wr_out.req && mem_ack_in;
    endsequence

    chk_fn_rsvd: assert property (
        s_rd(ufrt_pkg::FRAME_COUNT_OFS) |=> reg_rdata_out[31:16] == 16'h0)
        else $error("frame number upper bits not zero");
    chk_rem_rsvd: assert property (
        s_rd(ufrt_pkg::BITS_LEFT_OFS) |=> reg_rdata_out[30:14] == 17'h0)
        else $error("remaining reserved bits not zero");
    chk_run_entry: assert property (
        s_run_entry |-> ##[1:3] sof_req_out)
        else $error("no start of frame after entering run");
    chk_sof_hold: assert property (
        sof_req_out && !sof_ack_in |=> sof_req_out)
        else $error("token request dropped early");
    chk_sof_to_mem: assert property (
        s_sof_sent |=> !sof_req_out && mem_wr_out.req && mem_wr_out.data[31:16] == 16'h0)
        else $error("no number write after token");
    chk_mem_hold: assert property (
        mem_wr_out.req && !mem_ack_in |=> mem_wr_out.req && $stable(mem_wr_out.data)
            && $stable(mem_wr_out.addr))
        else $error("number write not held");
    chk_run_level: assert property (
        s_run_entry |-> ##3 running_out)
        else $error("running flag not raised after entry");
    chk_write_done: assert property (
        s_write_done |-> ed_fetch_go_out ##1 !mem_wr_out.req)
        else $error("write completion mishandled");
    chk_fetch_cause: assert property (
        ed_fetch_go_out |-> mem_wr_out.req && mem_ack_in)
        else $error("descriptor fetch before number write");
endmodule : ufrt_frame_timing_checker

bind ufrt_frame_timing ufrt_frame_timing_checker ufrt_frame_timing_checker_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .sof_req_out(sof_req_out), .sof_ack_in(sof_ack_in),
    .mem_wr_out(mem_wr_out), .mem_ack_in(mem_ack_in), .ed_fetch_go_out(ed_fetch_go_out),
    .running_out(running_out), .irq_out(irq_out));

`default_nettype wire
